// file: design/bts_pkg.sv
/*
 package for the branch trace store writer: register offsets, control bit
 positions, save-area field offsets, record sizes, carrier structs and states.
 assumes a 64-bit linear address space behind the memory port.
*/
package tsw_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PTR_LO = 8'h04;
  localparam logic [7:0] OFS_PTR_HI = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_SIZES = 8'h10;
  // control register bit positions
  localparam int CTRL_TRACE = 0;
  localparam int CTRL_STORE = 1;
  localparam int CTRL_BINT = 2;
  localparam int CTRL_SUPP_SUP = 3;
  localparam int CTRL_SUPP_USR = 4;
  localparam int CTRL_LONG_MODE = 5;
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // status register bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_THR_HIT = 1;
  // save-area management fields, 8 bytes each
  localparam logic [63:0] MGMT_BASE = 64'h0000_0000_0000_0000;
  localparam logic [63:0] MGMT_INDEX = 64'h0000_0000_0000_0008;
  localparam logic [63:0] MGMT_LIMIT = 64'h0000_0000_0000_0010;
  localparam logic [63:0] MGMT_THRESH = 64'h0000_0000_0000_0018;
  // record layout: source, target, flags, 8 bytes each
  localparam logic [63:0] FIELD_BYTES = 64'h0000_0000_0000_0008;
  localparam logic [63:0] BRANCH_REC_BYTES = 64'h0000_0000_0000_0018;
  localparam logic [7:0] SAMPLE_REC_BYTES = 8'h90;
  localparam int FLAG_PRED_BIT = 4;
  // branch event carrier
  typedef struct packed {
    logic [63:0] src;
    logic [63:0] dst;
    logic predicted;
    logic [1:0] priv_lvl; // privilege level of the branch
  } tsw_branch_t;
  // memory request carrier
  typedef struct packed {
    logic req;
    logic we;
    logic [63:0] addr;
    logic [63:0] wdata;
  } tsw_mem_req_t;
  // writer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_RD_BASE = 4'b0001,
    ST_RD_INDEX = 4'b0010,
    ST_RD_LIMIT = 4'b0011,
    ST_RD_THRESH = 4'b0100,
    ST_WR_SRC = 4'b0101,
    ST_WR_DST = 4'b0110,
    ST_WR_FLAGS = 4'b0111,
    ST_WR_INDEX = 4'b1000
  } tsw_state_t;
endpackage : tsw_pkg

// file: design/bts_writer.sv
/*
 branch trace store writer: takes taken-branch events, sends them out as
 trace messages or stores them as 24-byte records in a memory buffer that a
 save-area management block in memory describes; apb register slave.
 assumes a memory port that holds ack low until the request is served and
 software that sets up the save area and buffers correctly.
*/
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tsw_writer #(
  parameter bit PRED_SUPPORTED = 1'b1 // variant reports prediction status
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic br_valid,
  output logic br_ready,
  input wire tsw_pkg::tsw_branch_t br_info,
  output logic msg_valid,
  output tsw_pkg::tsw_branch_t msg_info,
  output tsw_pkg::tsw_mem_req_t mem_req,
  input wire logic [63:0] mem_rdata,
  input wire logic mem_ack,
  output logic buffer_int
);
  import tsw_pkg::*;

  // apb register state
  logic [5:0] ctrl_r, ctrl_nxt; // control flags
  logic [63:0] ptr_r, ptr_nxt; // save-area pointer register
  logic thr_hit_r, thr_hit_nxt; // sticky threshold reached
  logic [31:0] prdata_r, prdata_nxt; // read data latched in setup
  logic pslverr_r, pslverr_nxt; // unmapped address answer
  // writer state
  tsw_state_t state_r, state_nxt;
  tsw_branch_t rec_r, rec_nxt; // record being stored
  logic [63:0] base_r, base_nxt; // buffer base
  logic [63:0] idx_r, idx_nxt; // current index
  logic [63:0] lim_r, lim_nxt; // end limit
  logic [63:0] thr_r, thr_nxt; // interrupt threshold
  logic [63:0] nidx_r, nidx_nxt; // index written back
  tsw_mem_req_t mreq_r, mreq_nxt; // memory request
  logic msg_valid_r, msg_valid_nxt; // bus message strobe
  tsw_branch_t msg_r, msg_nxt; // bus message content
  logic int_r, int_nxt; // interrupt pulse
  // decoded terms
  logic wr_en; // apb write in access phase
  logic rd_setup; // apb transfer in setup phase, read or write
  logic store_ok; // privilege filter passes
  logic thr_event; // threshold met on index write-back
  logic [63:0] adv_idx; // index plus one record, or base when wrapping
  logic mapped; // address hits a register

  // apb handshake: zero wait states
  assign pready = 1'b1;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign br_ready = (state_r == ST_IDLE);
  assign msg_valid = msg_valid_r;
  assign msg_info = msg_r;
  assign mem_req = mreq_r;
  assign buffer_int = int_r;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_PTR_LO) || (paddr == OFS_PTR_HI)
    || (paddr == OFS_STATUS) || (paddr == OFS_SIZES);
  assign thr_event = (state_r == ST_WR_INDEX) && mem_ack && (nidx_r >= thr_r);

  // register file next values
  always_comb begin
    ctrl_nxt = ctrl_r;
    ptr_nxt = ptr_r;
    thr_hit_nxt = thr_hit_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (rd_setup) begin
      // answer decided in setup, shown in access
      pslverr_nxt = !mapped;
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        OFS_CTRL: prdata_nxt = {26'h000_0000, ctrl_r};
        OFS_PTR_LO: prdata_nxt = ptr_r[31:0];
        OFS_PTR_HI: prdata_nxt = ptr_r[63:32];
        OFS_STATUS: prdata_nxt = {30'h0000_0000, thr_hit_r, (state_r != ST_IDLE)};
        OFS_SIZES: prdata_nxt = {16'h0000, SAMPLE_REC_BYTES, BRANCH_REC_BYTES[7:0]};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: ctrl_nxt = pwdata[CTRL_W-1:0];
        OFS_PTR_LO: ptr_nxt[31:0] = pwdata;
        OFS_PTR_HI: ptr_nxt[63:32] = pwdata;
        OFS_STATUS: begin
          // write one clears
          if (pwdata[STAT_THR_HIT]) begin
            thr_hit_nxt = 1'b0;
          end
        end
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    // set wins over a clear in the same cycle
    if (thr_event) begin
      thr_hit_nxt = 1'b1;
    end
  end

  // register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      ptr_r <= 64'h0000_0000_0000_0000;
      thr_hit_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ptr_r <= ptr_nxt;
      thr_hit_r <= thr_hit_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  always_comb begin
    store_ok = 1'b1;
    if (ctrl_r[CTRL_SUPP_SUP] && (br_info.priv_lvl == 2'h0)) begin
      store_ok = 1'b0;
    end
    if (ctrl_r[CTRL_SUPP_USR] && (br_info.priv_lvl != 2'h0)) begin
      store_ok = 1'b0;
    end
  end

  always_comb begin
    adv_idx = idx_r + BRANCH_REC_BYTES;
    if (!ctrl_r[CTRL_BINT] && (adv_idx >= lim_r)) begin
      adv_idx = base_r;
    end
  end

  // writer next values
  always_comb begin
    state_nxt = state_r;
    rec_nxt = rec_r;
    base_nxt = base_r;
    idx_nxt = idx_r;
    lim_nxt = lim_r;
    thr_nxt = thr_r;
    nidx_nxt = nidx_r;
    mreq_nxt = mreq_r;
    msg_valid_nxt = 1'b0;
    msg_nxt = msg_r;
    int_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        // nothing produced while trace is off
        if (br_valid && ctrl_r[CTRL_TRACE]) begin
          if (!ctrl_r[CTRL_STORE]) begin
            msg_valid_nxt = 1'b1;
            msg_nxt = br_info;
          end else if (store_ok) begin
            rec_nxt = br_info;
            // management area at the 64-bit pointer
            mreq_nxt = '{req: 1'b1, we: 1'b0, addr: ptr_r + MGMT_BASE, wdata: 64'h0};
            state_nxt = ST_RD_BASE;
          end
        end
      end
      ST_RD_BASE: begin
        if (mem_ack) begin
          base_nxt = mem_rdata;
          mreq_nxt.addr = ptr_r + MGMT_INDEX;
          state_nxt = ST_RD_INDEX;
        end
      end
      ST_RD_INDEX: begin
        if (mem_ack) begin
          idx_nxt = mem_rdata;
          mreq_nxt.addr = ptr_r + MGMT_LIMIT;
          state_nxt = ST_RD_LIMIT;
        end
      end
      ST_RD_LIMIT: begin
        if (mem_ack) begin
          lim_nxt = mem_rdata;
          mreq_nxt.addr = ptr_r + MGMT_THRESH;
          state_nxt = ST_RD_THRESH;
        end
      end
      ST_RD_THRESH: begin
        if (mem_ack) begin
          thr_nxt = mem_rdata;
          mreq_nxt = '{req: 1'b1, we: 1'b1, addr: idx_r, wdata: rec_r.src};
          state_nxt = ST_WR_SRC;
        end
      end
      ST_WR_SRC: begin
        if (mem_ack) begin
          // target in the second 8-byte field
          mreq_nxt.addr = idx_r + FIELD_BYTES;
          mreq_nxt.wdata = rec_r.dst;
          state_nxt = ST_WR_DST;
        end
      end
      ST_WR_DST: begin
        if (mem_ack) begin
          mreq_nxt.addr = idx_r + FIELD_BYTES + FIELD_BYTES;
          mreq_nxt.wdata = 64'h0;
          mreq_nxt.wdata[FLAG_PRED_BIT] = PRED_SUPPORTED && rec_r.predicted;
          state_nxt = ST_WR_FLAGS;
        end
      end
      ST_WR_FLAGS: begin
        if (mem_ack) begin
          // keeps storing past the limit in interrupt mode
          nidx_nxt = adv_idx;
          mreq_nxt.addr = ptr_r + MGMT_INDEX;
          mreq_nxt.wdata = adv_idx;
          state_nxt = ST_WR_INDEX;
        end
      end
      ST_WR_INDEX: begin
        if (mem_ack) begin
          int_nxt = thr_event;
          mreq_nxt.req = 1'b0;
          mreq_nxt.we = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        mreq_nxt.req = 1'b0;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // writer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      rec_r <= '0;
      base_r <= 64'h0;
      idx_r <= 64'h0;
      lim_r <= 64'h0;
      thr_r <= 64'h0;
      nidx_r <= 64'h0;
      mreq_r <= '0;
      msg_valid_r <= 1'b0;
      msg_r <= '0;
      int_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rec_r <= rec_nxt;
      base_r <= base_nxt;
      idx_r <= idx_nxt;
      lim_r <= lim_nxt;
      thr_r <= thr_nxt;
      nidx_r <= nidx_nxt;
      mreq_r <= mreq_nxt;
      msg_valid_r <= msg_valid_nxt;
      msg_r <= msg_nxt;
      int_r <= int_nxt;
    end
  end

  // checks on the writer
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus message only from an enabled, unselected trace
  a_msg_source: assert property (msg_valid_r |-> $past(ctrl_r[CTRL_TRACE])
    && !$past(ctrl_r[CTRL_STORE]) && $past(br_valid))
    else $error("trace message without enable or while storing");
  // no store with trace off
  a_trace_off: assert property ((state_r == ST_IDLE) && !ctrl_r[CTRL_TRACE]
    |=> (state_r == ST_IDLE) && !msg_valid_r)
    else $error("activity with trace disabled");
  // both suppressions store nothing
  a_both_suppressed: assert property ((state_r == ST_IDLE) && br_valid
    && ctrl_r[CTRL_SUPP_SUP] && ctrl_r[CTRL_SUPP_USR] |=> state_r == ST_IDLE)
    else $error("record stored with both suppressions set");
  // supervisor records dropped when suppressed
  a_supervisor_drop: assert property ((state_r == ST_IDLE) && br_valid
    && ctrl_r[CTRL_SUPP_SUP] && (br_info.priv_lvl == 2'h0) |=> state_r == ST_IDLE)
    else $error("level-0 record stored while suppressed");
  // management reads start at the pointer
  a_mgmt_pointer: assert property ((state_r == ST_IDLE) ##1 (state_r == ST_RD_BASE)
    |-> mreq_r.req && !mreq_r.we && (mreq_r.addr == ptr_r))
    else $error("management read not at save-area pointer");

  // target field 8 bytes after source
  a_target_field: assert property ((state_r == ST_WR_DST)
    |-> mreq_r.we && (mreq_r.addr == idx_r + FIELD_BYTES) && (mreq_r.wdata == rec_r.dst))
    else $error("target field misplaced");

  // predicted bit follows variant support
  a_pred_flag: assert property ((state_r == ST_WR_FLAGS)
    |-> mreq_r.wdata[FLAG_PRED_BIT] == (PRED_SUPPORTED && rec_r.predicted))
    else $error("predicted flag wrong");

  // index advances one record or wraps
  a_index_advance: assert property ((state_r == ST_WR_INDEX) |-> mreq_r.wdata ==
    ((!ctrl_r[CTRL_BINT] && (idx_r + BRANCH_REC_BYTES >= lim_r)) ? base_r
    : idx_r + BRANCH_REC_BYTES))
    else $error("index write-back wrong");

  // interrupt whenever the written-back index is at or above threshold
  a_threshold_int: assert property ((state_r == ST_WR_INDEX) && mem_ack
    |=> buffer_int == $past(nidx_r >= thr_r))
    else $error("threshold interrupt wrong");

  // request held until served
  a_req_held: assert property (mreq_r.req && !mem_ack && (state_r != ST_IDLE)
    |=> $stable(mreq_r.addr) && $stable(mreq_r.wdata))
    else $error("memory request changed before ack");

  // main scenarios
  c_bus_msg: cover property (msg_valid_r);
  c_circular_wrap: cover property ((state_r == ST_WR_INDEX) && (mreq_r.wdata == base_r)
    && !ctrl_r[CTRL_BINT]);
  c_interrupt: cover property (buffer_int && ctrl_r[CTRL_BINT]);
  c_circular_int: cover property (buffer_int && !ctrl_r[CTRL_BINT]);
endmodule : tsw_writer
`default_nettype wire

// file: test/bts_mem_model.sv
/*
 memory model on the writer's store port: words keyed by byte address.
 assumes each request is held until ack; lat sets the wait before ack.
*/
`timescale 1ns/1ns
`default_nettype none
module tsw_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire tsw_pkg::tsw_mem_req_t mem_req,
  input wire logic [3:0] lat,
  output logic [63:0] mem_rdata,
  output logic mem_ack
);
  import tsw_pkg::*;
  // one flat address map for every access
  logic [63:0] mem [logic [63:0]]; // word store
  logic [3:0] cnt_r; // cycles waited
  // one ack after lat cycles; read data scrambles outside the ack cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 64'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.req && !mem_ack) begin
        if (cnt_r == lat) begin
          cnt_r <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_req.we) mem[mem_req.addr] = mem_req.wdata;
          else mem_rdata <= mem[mem_req.addr];
        end else cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule : tsw_mem_model
`default_nettype wire

// file: test/bts_writer_tb.sv
/*
 testbench for the branch trace store writer: apb set-up, table of control
 encodings, then circular wrap, threshold, interrupt mode and reset cases.
 assumes the memory model above on the store port.
*/
`timescale 1ns/1ns
`default_nettype none
module tsw_writer_tb;
  import tsw_pkg::*;
  // contiguous area, address bit 20 zero
  localparam logic [63:0] PTR = 64'h0000_0001_0000_1000; // management area
  localparam logic [63:0] BASE = 64'h0000_0001_0000_2000; // branch buffer
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, br_ready, msg_valid, mem_ack, buffer_int, e;
  logic br_valid = 1'b0;
  tsw_branch_t br_info = '0;
  tsw_branch_t msg_info;
  tsw_mem_req_t mem_req;
  logic [63:0] mem_rdata, s;
  logic [3:0] lat = 4'h0;
  int fails = 0, num_checks = 0, msgs = 0, ints = 0, cyc = 0, m, n;
  // control bits, privilege, predicted, message and store expected
  typedef struct {logic [5:0] c; logic [1:0] l; logic p; logic em; logic es;} tsw_row_t;
  tsw_row_t rows [9] = '{'{6'h00, 2'h0, 1'h1, 1'h0, 1'h0}, '{6'h01, 2'h3, 1'h0, 1'h1, 1'h0},
    '{6'h03, 2'h2, 1'h1, 1'h0, 1'h1}, '{6'h0b, 2'h0, 1'h0, 1'h0, 1'h0},
    '{6'h0b, 2'h3, 1'h1, 1'h0, 1'h1}, '{6'h13, 2'h1, 1'h0, 1'h0, 1'h0},
    '{6'h17, 2'h0, 1'h1, 1'h0, 1'h1}, '{6'h1f, 2'h0, 1'h0, 1'h0, 1'h0},
    '{6'h23, 2'h1, 1'h0, 1'h0, 1'h1}};
  tsw_writer tsw_writer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .br_valid, .br_ready, .br_info, .msg_valid, .msg_info,
    .mem_req, .mem_rdata, .mem_ack, .buffer_int);
  tsw_mem_model tsw_mem_model_inst (.pclk, .presetn, .mem_req, .lat, .mem_rdata, .mem_ack);
  always #20 pclk = ~pclk;
  // pulse counters and run ceiling
  // buffer_int taken as delivered interrupt
  always @(posedge pclk) begin
    cyc++;
    if (msg_valid === 1'b1) msgs++;
    if (buffer_int === 1'b1) ints++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  task chk(input string nm, input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [63:0] rd(input logic [63:0] a);
    return tsw_mem_model_inst.mem[a];
  endfunction : rd
  task setup(input logic [63:0] idx, thr, input logic [5:0] c);
    // aligned base, three-record buffer, then flags
    tsw_mem_model_inst.mem[PTR] = BASE;
    tsw_mem_model_inst.mem[PTR + 64'h8] = idx;
    tsw_mem_model_inst.mem[PTR + 64'h10] = BASE + 64'h48;
    tsw_mem_model_inst.mem[PTR + 64'h18] = thr;
    apb(1'b1, OFS_CTRL, {26'h0, c});
  endtask : setup
  // offer one event, then wait for the writer to go idle
  task branch(input logic [1:0] l, input logic p, input logic [63:0] src);
    @(posedge pclk);
    br_valid <= 1'b1;
    br_info <= '{src, ~src, p, l};
    @(posedge pclk);
    br_valid <= 1'b0;
    @(posedge pclk);
    while (br_ready !== 1'b1 || mem_req.req !== 1'b0) @(posedge pclk);
    @(posedge pclk);
  endtask : branch
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(posedge pclk);
    chk("req in reset", mem_req.req, 1'h0);
    chk("ready in reset", br_ready, 1'h1);
    presetn <= 1'b1;
    apb(1'b0, OFS_SIZES, 32'h0);
    chk("sizes", q, 32'h0000_9018);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", e, 1'h1);
    apb(1'b1, OFS_PTR_LO, PTR[31:0]);
    apb(1'b1, OFS_PTR_HI, PTR[63:32]);
    apb(1'b0, OFS_PTR_HI, 32'h0);
    chk("pointer high", q, PTR[63:32]);
    $display("test registers done");
    foreach (rows[i]) begin
      setup(BASE, '1, rows[i].c);
      m = msgs;
      n = ints;
      s = 64'hffff_8000_0000_0100 + 64'(i);
      branch(rows[i].l, rows[i].p, s);
      chk("message", 64'(msgs - m), 64'(rows[i].em));
      chk("no int", 64'(ints - n), 64'h0);
      chk("index", rd(PTR + 64'h8), rows[i].es ? BASE + 64'h18 : BASE);
      if (rows[i].em) chk("msg src", msg_info.src, s);
      if (rows[i].es) begin
        chk("rec src", rd(BASE), s);
        chk("rec dst", rd(BASE + 64'h8), ~s);
        chk("rec flags", rd(BASE + 64'h10), {59'h0, rows[i].p, 4'h0});
      end
    end
    $display("test encodings done");
    // circular wrap with threshold inside the buffer
    setup(BASE, BASE + 64'h30, 6'h03);
    n = ints;
    for (int k = 0; k < 4; k++) branch(2'h3, 1'h0, 64'h100 + 64'(k));
    chk("wrap index", rd(PTR + 64'h8), BASE + 64'h18);
    chk("circ ints", 64'(ints - n), 64'h1);
    chk("overwrite", rd(BASE), 64'h103);
    chk("third rec", rd(BASE + 64'h30), 64'h102);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("thr flag", q, 32'h0000_0002);
    chk("mapped err", e, 1'h0);
    apb(1'b1, OFS_STATUS, 32'h0000_0002);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("thr cleared", q, 32'h0);
    $display("test circular done");
    // interrupt mode keeps storing past the limit, slow memory
    lat <= 4'h3;
    setup(BASE + 64'h30, BASE + 64'h30, 6'h07);
    n = ints;
    for (int k = 0; k < 2; k++) branch(2'h0, 1'h1, 64'h200 + 64'(k));
    chk("past limit", rd(PTR + 64'h8), BASE + 64'h60);
    chk("int count", 64'(ints - n), 64'h2);
    chk("rec at limit", rd(BASE + 64'h48), 64'h201);
    $display("test interrupt done");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl after reset", q, 32'h0);
    $display("test reset done");
    conclude();
  end
endmodule : tsw_writer_tb
`default_nettype wire
